/* File: hdl/synth_sync_map.svh */
// offsets, field positions, reset values and constants of the sync and phase control block
`ifndef SYNTH_SYNC_MAP_SVH
`define SYNTH_SYNC_MAP_SVH
`define REG_CTRL        8'h00
`define REG_CFG         8'h04
`define REG_DEN         8'h08
`define REG_NUM         8'h0C
`define REG_SEED        8'h10
`define REG_STATUS      8'h14
`define REG_PHASE       8'h18
`define CTRL_PD_BIT     0
`define CTRL_CAL_BIT    1
`define CTRL_SYNC_BIT   2
`define CTRL_MASK_BIT   3
`define CTRL_MRST_BIT   4
`define CFG_CHANNEL_DIVIDE_VALUE_LSB   0
`define CFG_OUTA_LSB    8
`define CFG_OUTB_LSB    12
`define CFG_ORDER_LSB   16
`define CTRL_RESET      32'h0000_0009
`define CFG_RESET       32'h0000_1100
`define DEN_RESET       32'h0000_0001
`define MUX_CHANNEL_DIVIDE_VALUE       3'h0
`define MUX_VCO         3'h1
`define MUX_SYSREF      3'h2
`define CHANNEL_DIVIDE_VALUE_IDX_2     5'h00
`define CHANNEL_DIVIDE_VALUE_IDX_24    5'h06
`define CHANNEL_DIVIDE_VALUE_IDX_192   5'h0D
`endif

/* File: hdl/synth_sync_pkg.sv */
// types of the sync and phase control block
package synth_sync_pkg;
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_ARMED = 2'b01,
    ST_FIRE  = 2'b10
  } sync_state_t;
endpackage : synth_sync_pkg

/* File: hdl/sync_reclock.sv */
// reclocks a sync request to the next rising edge of the reference input
`timescale 1ns/100ps
`default_nettype none
module sync_reclock (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic request,
  input  wire logic ref_clk_in,
  output logic      fire
);
  typedef struct packed {
    synth_sync_pkg::sync_state_t st;
    logic                        ref_d;
    logic                        fire;
  } rc_t;
  rc_t r;
  rc_t next_r;
  always_comb begin
    next_r      = r;
    next_r.ref_d = ref_clk_in;
    next_r.fire = 1'b0;
    unique case (r.st)
      synth_sync_pkg::ST_IDLE: begin
        if (request) begin
          next_r.st = synth_sync_pkg::ST_ARMED;
        end
      end
      synth_sync_pkg::ST_ARMED: begin
        if (ref_clk_in && !r.ref_d) begin
          next_r.st   = synth_sync_pkg::ST_FIRE;
          next_r.fire = 1'b1;
        end
      end
      synth_sync_pkg::ST_FIRE: begin
        next_r.st = synth_sync_pkg::ST_IDLE;
      end
      default: next_r.st = synth_sync_pkg::ST_IDLE;
    endcase
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end
  assign fire = r.fire;
  // fire is registered: the edge it answers was seen one and two samples back
  fire_on_edge_a: assert property (@(posedge hclk) disable iff (!hresetn)
    fire |-> $past(r.st) == synth_sync_pkg::ST_ARMED && $past(ref_clk_in) &&
             !$past(ref_clk_in, 2))
    else $error("sync fired away from a reference rising edge");
endmodule : sync_reclock
`default_nettype wire

/* File: hdl/synth_phase_sync_adjust.sv */
// power-down, phase sync and seed phase adjust control of the synthesizer
//
// Register access over AHB-Lite and the register offsets were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "synth_sync_map.svh"
module synth_phase_sync_adjust (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        chip_enable,
  input  wire logic        sync_pin,
  input  wire logic        reference_input,
  output logic             powered_down,
  output logic             vco_cal_start,
  output logic             modulator_reset,
  output logic             channel_divider_power,
  output logic [2:0]       feedback_included_divide
);
  typedef struct packed {
    logic [31:0] ctrl;
    logic [31:0] cfg;
    logic [31:0] den;
    logic [31:0] num;
    logic [31:0] seed;
    logic [31:0] phase_acc;
    logic        wr_pend;
    logic [7:0]  wr_addr;
    logic [31:0] rdata;
    logic        pin_d;
    logic        sync_pend;
    logic        cal_start;
    logic        mrst;
    logic [3:0]  sync_count;
  } state_t;
  state_t r;
  state_t next_r;
  logic   sync_fire;
  logic   sync_req;
  logic   pin_edge;
  logic   sw_sync;
  logic   mrst_req;
  // included divide from selectors and channel divide index
  function automatic logic [2:0] incl_div(input logic [31:0] cfg);
    logic [2:0] a;
    logic [2:0] b;
    logic [4:0] c;
    a = cfg[`CFG_OUTA_LSB +: 3];
    b = cfg[`CFG_OUTB_LSB +: 3];
    c = cfg[`CFG_CHANNEL_DIVIDE_VALUE_LSB +: 5];
    if (a == `MUX_VCO && b == `MUX_VCO) begin
      incl_div = 3'h1;
    end else if (c != `CHANNEL_DIVIDE_VALUE_IDX_24 && c != `CHANNEL_DIVIDE_VALUE_IDX_192 &&
                 (c == 5'h02 || c == 5'h04 || c == 5'h06 || c == 5'h08 ||
                  c == 5'h0A || c == 5'h0B || c == 5'h0D || c == 5'h0F ||
                  c == 5'h11)) begin
      incl_div = 3'h6;
    end else begin
      incl_div = 3'h4;
    end
  endfunction : incl_div
  // ready is always high, so every selected nonseq transfer is taken with no wait state
  wire logic addr_phase = hsel && hready && htrans[1];
  assign pin_edge = sync_pin && !r.pin_d && !r.ctrl[`CTRL_MASK_BIT];
  always_comb begin
    next_r           = r;
    next_r.pin_d     = sync_pin;
    next_r.cal_start = 1'b0;
    next_r.mrst      = 1'b0;
    sw_sync          = 1'b0;
    mrst_req         = 1'b0;
    next_r.wr_pend   = 1'b0;
    if (addr_phase) begin
      next_r.wr_pend = hwrite;
      next_r.wr_addr = haddr[7:0];
      unique case (haddr[7:0])
        `REG_CTRL:   next_r.rdata = r.ctrl;
        `REG_CFG:    next_r.rdata = r.cfg;
        `REG_DEN:    next_r.rdata = r.den;
        `REG_NUM:    next_r.rdata = r.num;
        `REG_SEED:   next_r.rdata = r.seed;
        `REG_STATUS: next_r.rdata = {24'h000000, r.sync_count, 1'b0,
                                     feedback_included_divide};
        `REG_PHASE:  next_r.rdata = r.phase_acc;
        default:     next_r.rdata = 32'h0000_0000;
      endcase
    end
    if (r.wr_pend) begin
      unique case (r.wr_addr)
        `REG_CTRL: begin
          next_r.ctrl = hwdata;
          // software sync: stored bit goes 0 to 1, no second sync on rewrite
          sw_sync = hwdata[`CTRL_SYNC_BIT] && !r.ctrl[`CTRL_SYNC_BIT];
          mrst_req = hwdata[`CTRL_MRST_BIT];
        end
        `REG_CFG:  next_r.cfg = hwdata;
        `REG_DEN:  next_r.den = hwdata;
        `REG_NUM:  next_r.num = hwdata;
        `REG_SEED: begin
          next_r.seed = hwdata;
          // seed only moves phase when modulator order is nonzero
          if (r.cfg[`CFG_ORDER_LSB +: 3] != 3'h0) begin
            next_r.phase_acc = r.phase_acc + hwdata;
          end
        end
        default: ;
      endcase
    end
    // a pin edge takes the same reclock path; sets win over the arming clear
    if (sync_req) begin
      next_r.sync_pend = 1'b0;
    end
    // with calibration disabled the pin is inert, for sync as well as calibration
    if (pin_edge && r.ctrl[`CTRL_SYNC_BIT] && r.ctrl[`CTRL_CAL_BIT]) begin
      next_r.sync_pend = 1'b1;
    end
    if (sw_sync) begin
      next_r.sync_pend = 1'b1;
    end
    if (pin_edge && r.ctrl[`CTRL_CAL_BIT]) begin
      next_r.cal_start = 1'b1;
    end
    // a modulator reset write counts too, so status shows every phase restart
    if (sync_fire || mrst_req) begin
      next_r.phase_acc = 32'h0000_0000;
      next_r.mrst      = 1'b1;
      next_r.sync_count = r.sync_count + 4'h1;
    end
  end
  assign sync_req = r.sync_pend;
  sync_reclock u_reclock (
    .hclk       (hclk),
    .hresetn    (hresetn),
    .request    (sync_req),
    .ref_clk_in (reference_input),
    .fire       (sync_fire)
  );
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      // only the registers with nonzero reset values are named after the clear
      r      <= '0;
      r.ctrl <= `CTRL_RESET;
      r.cfg  <= `CFG_RESET;
      r.den  <= `DEN_RESET;
    end else begin
      r <= next_r;
    end
  end
  assign hrdata    = r.rdata;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign powered_down = !chip_enable || r.ctrl[`CTRL_PD_BIT];
  assign vco_cal_start = r.cal_start;
  assign modulator_reset = r.mrst;
  assign feedback_included_divide = r.ctrl[`CTRL_SYNC_BIT] ? incl_div(r.cfg) : 3'h1;
  assign channel_divider_power = r.cfg[`CFG_OUTA_LSB +: 3] == `MUX_CHANNEL_DIVIDE_VALUE ||
                                 r.cfg[`CFG_OUTB_LSB +: 3] == `MUX_CHANNEL_DIVIDE_VALUE ||
                                 r.cfg[`CFG_OUTB_LSB +: 3] == `MUX_SYSREF;
  wire logic sync_pend_or_fire = r.sync_pend || sync_fire;
  power_either_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (!chip_enable || r.ctrl[`CTRL_PD_BIT]) |-> powered_down)
    else $error("power-down source ignored");
  incl_vco_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (r.ctrl[`CTRL_SYNC_BIT] && r.cfg[10:8] == 3'h1 && r.cfg[14:12] == 3'h1)
    |-> feedback_included_divide == 3'h1)
    else $error("included divide not one with vco outputs");
  incl_excl_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (r.ctrl[`CTRL_SYNC_BIT] && !(r.cfg[10:8] == 3'h1 && r.cfg[14:12] == 3'h1) &&
     (r.cfg[4:0] == `CHANNEL_DIVIDE_VALUE_IDX_24 || r.cfg[4:0] == `CHANNEL_DIVIDE_VALUE_IDX_192))
    |-> feedback_included_divide == 3'h4)
    else $error("included divide not four for excluded channel divides");
  sw_sync_a: assert property (@(posedge hclk) disable iff (!hresetn)
    sw_sync |=> sync_pend_or_fire)
    else $error("software sync lost");
  no_resync_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (r.wr_pend && r.ctrl[`CTRL_SYNC_BIT] && !pin_edge) |-> !sw_sync)
    else $error("rewrite of set sync bit made an event");
  cal_gate_a: assert property (@(posedge hclk) disable iff (!hresetn)
    vco_cal_start |-> $past(r.ctrl[`CTRL_CAL_BIT]) && $past(sync_pin) && !$past(r.pin_d))
    else $error("calibration started without enable and edge");
  pin_no_cal_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (pin_edge && !r.ctrl[`CTRL_CAL_BIT] && !sw_sync) |=> !r.sync_pend)
    else $error("sync pin acted with calibration disabled");
  phase_zero_a: assert property (@(posedge hclk) disable iff (!hresetn)
    sync_fire |=> r.phase_acc == 32'h0000_0000)
    else $error("phase not zeroed by sync");
  mrst_zero_a: assert property (@(posedge hclk) disable iff (!hresetn)
    mrst_req |=> r.phase_acc == 32'h0000_0000 && modulator_reset)
    else $error("modulator reset write did not restart phase");
  seed_order_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (r.wr_pend && r.wr_addr == `REG_SEED && r.cfg[18:16] == 3'h0 && !sync_fire && !mrst_req)
    |=> $stable(r.phase_acc))
    else $error("seed moved phase with order zero");
  channel_divide_value_pwr_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (r.cfg[10:8] != 3'h0 && r.cfg[14:12] != 3'h0 && r.cfg[14:12] != 3'h2)
    |-> !channel_divider_power)
    else $error("channel divider powered needlessly");
endmodule : synth_phase_sync_adjust
`default_nettype wire

/* File: tb/sync_host_model.sv */
// behavioural host that drives the reference input and the sync pin
`timescale 1ns/100ps
`default_nettype none
module sync_host_model (
  input  wire logic hclk,
  output logic      reference_input,
  output logic      sync_pin
);
  initial begin
    reference_input = 1'b0;
    sync_pin = 1'b0;
  end
  // the reference only runs on request, so a waiting reclock can be seen to wait
  task automatic ref_edges(input integer n);
    repeat (n) begin
      @(posedge hclk) reference_input <= 1'b1;
      repeat (2) @(posedge hclk);
      reference_input <= 1'b0;
      repeat (2) @(posedge hclk);
    end
  endtask : ref_edges
  // the edge falls while the reference is held low, well away from its rising edges
  task automatic pin_rise;
    @(posedge hclk) sync_pin <= 1'b1;
    repeat (3) @(posedge hclk);
    sync_pin <= 1'b0;
  endtask : pin_rise
endmodule : sync_host_model
`default_nettype wire

/* File: tb/synth_phase_sync_adjust_tb.sv */
// self-checking bench for the sync and phase control block
`timescale 1ns/100ps
`default_nettype none
`include "synth_sync_map.svh"
module synth_phase_sync_adjust_tb;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hwrite = 1'b0;
  logic        hsel = 1'b0;
  logic        desel = 1'b0;
  logic [2:0]  hsize = 3'h0;
  logic        chip_enable = 1'b1;
  logic        rd_ph = 1'b0;
  logic        snap = 1'b0;
  logic        cp;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  a, b, inc;
  logic [4:0]  idx;
  logic [7:0]  cal_cnt = 8'h00;
  logic [7:0]  mrst_cnt = 8'h00;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, got, exp_v;
  logic [31:0] exp_q[$];
  integer      n_mismatch = 0, n_checks = 0, i;
  integer      seed = 32'h65520B77;
  wire         hreadyout, hresp, powered_down, vco_cal_start, modulator_reset;
  wire         channel_divider_power, reference_input, sync_pin;
  wire [2:0]   feedback_included_divide;
  wire [31:0]  hrdata;
  // hresp rides in a spare bit, so every snapshot also checks the OKAY response
  wire [31:0]  obs = {cal_cnt, mrst_cnt, 10'h000, hresp, powered_down, channel_divider_power,
                      feedback_included_divide};
  synth_phase_sync_adjust synth_phase_sync_adjust_inst (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .chip_enable(chip_enable), .sync_pin(sync_pin),
    .reference_input(reference_input), .powered_down(powered_down),
    .vco_cal_start(vco_cal_start), .modulator_reset(modulator_reset),
    .channel_divider_power(channel_divider_power),
    .feedback_included_divide(feedback_included_divide));
  sync_host_model sync_host_model_inst (.hclk(hclk), .reference_input(reference_input),
    .sync_pin(sync_pin));
  always #2.5 hclk = ~hclk;
  always @(posedge hclk) begin
    if (vco_cal_start === 1'b1) cal_cnt <= cal_cnt + 8'h01;
    if (modulator_reset === 1'b1) mrst_cnt <= mrst_cnt + 8'h01;
  end
  // one queue serves read data and port snapshots, in the order they were asked for
  always @(posedge hclk) begin
    if ((rd_ph && hreadyout === 1'b1) || snap) begin
      got = rd_ph ? hrdata : obs;
      exp_v = exp_q.pop_front();
      n_checks = n_checks + 1;
      if (got !== exp_v) begin
        n_mismatch = n_mismatch + 1;
        $display("Error at %0t: got %h expected %h", $time, got, exp_v);
      end
    end
  end
  function automatic logic [31:0] ob(input logic [7:0] c, m, input logic p, d,
                                     input logic [2:0] n);
    return {c, m, 11'h000, p, d, n};
  endfunction : ob
  task test_done;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : test_done
  task automatic wait_rdy;
    integer k;
    k = 0;
    do begin
      @(posedge hclk);
      k = k + 1;
    end while (hreadyout !== 1'b1 && k < 20);
    if (hreadyout !== 1'b1) begin
      n_mismatch = n_mismatch + 1;
      test_done;
    end
  endtask : wait_rdy
  // for a read, d is the expected word
  task automatic bus(input logic wr, input logic [7:0] adr, input logic [31:0] d);
    @(posedge hclk);
    if (!wr) exp_q.push_back(d);
    htrans <= 2'h2;
    hsel <= !desel;
    hsize <= 3'h2;
    haddr <= {24'h0, adr};
    hwrite <= wr;
    wait_rdy;
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wr ? d : 32'h0;
    rd_ph <= !wr;
    wait_rdy;
    rd_ph <= 1'b0;
  endtask : bus
  task automatic look(input logic [31:0] e);
    @(posedge hclk);
    exp_q.push_back(e);
    snap <= 1'b1;
    @(posedge hclk);
    snap <= 1'b0;
  endtask : look
  initial begin
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    look(ob(0, 0, 1, 0, 1));
    bus(0, `REG_CTRL, `CTRL_RESET);
    bus(0, `REG_CFG, `CFG_RESET);
    bus(0, `REG_DEN, `DEN_RESET);
    bus(0, 8'h1C, 32'h0);
    // a transfer with the select low must leave the register alone
    desel = 1'b1;
    bus(1, `REG_DEN, 32'h55);
    desel = 1'b0;
    bus(0, `REG_DEN, `DEN_RESET);
    $display("reset test done");
    for (i = 0; i < 4; i++) begin
      @(posedge hclk) chip_enable <= i[0];
      bus(1, `REG_CTRL, {28'h0, 1'b1, 2'b00, i[1]});
      look(ob(0, 0, !i[0] | i[1], 0, 1));
    end
    bus(1, `REG_CTRL, 32'h0000000A);
    $display("power test done");
    bus(1, `REG_CTRL, 32'h0000000E);
    repeat (10) @(posedge hclk);
    look(ob(0, 0, 0, 0, 1));
    sync_host_model_inst.ref_edges(1);
    look(ob(0, 1, 0, 0, 1));
    bus(0, `REG_STATUS, 32'h11);
    bus(1, `REG_CTRL, 32'h0000000E);
    sync_host_model_inst.ref_edges(2);
    look(ob(0, 1, 0, 0, 1));
    $display("software sync test done");
    bus(1, `REG_DEN, 32'h100);
    bus(1, `REG_NUM, 32'h0);
    for (i = 0; i < 12; i++) begin
      a = 3'($unsigned($random(seed)) % 3);
      b = 3'($unsigned($random(seed)) % 3);
      idx = 5'($unsigned($random(seed)) % 18);
      inc = (a == 1 && b == 1) ? 3'h1 : (((32'h28D14 >> idx) & 1) ? 3'h6 : 3'h4);
      cp = (a == 0) || (b == 0) || (b == 2);
      bus(1, `REG_CFG, {13'h0, 3'h2, 1'b0, b, 1'b0, a, 3'h0, idx});
      look(ob(0, 1, 0, cp, inc));
      bus(0, `REG_STATUS, {24'h0, 4'h1, 1'b0, inc});
    end
    $display("divide test done");
    bus(1, `REG_CTRL, 32'h00000006);
    sync_host_model_inst.pin_rise();
    look(ob(1, 1, 0, cp, inc));
    sync_host_model_inst.ref_edges(1);
    look(ob(1, 2, 0, cp, inc));
    bus(1, `REG_CTRL, 32'h00000004);
    sync_host_model_inst.pin_rise();
    sync_host_model_inst.ref_edges(1);
    look(ob(1, 2, 0, cp, inc));
    $display("pin sync test done");
    bus(1, `REG_SEED, 32'h5);
    bus(1, `REG_SEED, 32'h3);
    bus(0, `REG_PHASE, 32'h8);
    bus(1, `REG_CTRL, 32'h00000014);
    bus(0, `REG_PHASE, 32'h0);
    bus(1, `REG_SEED, 32'h7);
    bus(1, `REG_CTRL, 32'h00000008);
    bus(1, `REG_CTRL, 32'h00000004);
    sync_host_model_inst.ref_edges(1);
    bus(0, `REG_PHASE, 32'h0);
    bus(0, `REG_STATUS, {24'h0, 4'h4, 1'b0, inc});
    bus(1, `REG_CFG, {13'h0, 3'h0, 1'b0, b, 1'b0, a, 3'h0, idx});
    bus(1, `REG_SEED, 32'h9);
    bus(0, `REG_PHASE, 32'h0);
    $display("seed test done");
    test_done;
  end
endmodule : synth_phase_sync_adjust_tb
`default_nettype wire
